//--- oam_pdu_formatter.sv
// oam pdu formatter: builds outgoing pdus, parses incoming ones
// Function
// - client control request sets or clears outgoing critical-event bits.
// - peer critical-event flags are delivered with each pdu indication.
// - with link events supported and local pdu set to any, every received event pdu is forwarded.
// - pdus carry no vlan tag; frames are emitted and parsed untagged.
// - fault-report-only: information pdu carries no information tlvs.
// - peer state unknown: information pdu carries only the local tlv.
// - peer state known: information pdu carries local and remote tlvs.
// - event pdu data starts with a 16-bit unsigned sequence number.
// - event pdu holds at least one link event tlv after the sequence.
// - variable request and response pdus are never sent empty.
// - if not passive and loopback supported: one command per loopback pdu.
// - listen-only: no pdu of any kind is transmitted.
// - tlv-report-only: only information pdus are transmitted.
`timescale 1ns/1ps
module oam_pdu_formatter
    import oam_pkg::*;
#(
    parameter int TLV_LEN = 16
) (
    // clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_rst,
    // configuration and state
    input  wire oam_perm_e          i_local_pdu,
    input  wire logic               i_passive,
    input  wire logic               i_link_event_support,
    input  wire logic               i_remote_loopback_support,
    input  wire logic               i_remote_state_valid,
    input  wire logic [1:0]         i_loc_state,
    input  wire logic [1:0]         i_rem_state,
    input  wire logic [TLV_LEN*8-1:0] i_loc_tlv,
    input  wire logic [TLV_LEN*8-1:0] i_rem_tlv,
    // critical event control
    input  wire logic               i_ctl_valid,
    input  wire logic [2:0]         i_ctl_crit,
    // pdu request
    input  wire logic               i_req_valid,
    input  wire oam_req_s           i_req,
    output logic                    o_req_ack,
    output logic                    o_req_rej,
    // request payload bytes
    input  wire logic               i_pay_valid,
    input  wire logic [7:0]         i_pay_data,
    output logic                    o_pay_ready,
    // transmit and receive byte streams
    output oam_byte_s               o_tx,
    input  wire oam_byte_s          i_rx,
    // receive indication and local critical flags
    output logic                    o_ind_valid,
    output oam_ind_s                o_ind,
    output logic [2:0]              o_rem_crit,
    output logic [2:0]              o_loc_crit
);

    if (TLV_LEN < 2 || TLV_LEN > 127) begin : g_bad_len
        $error("TLV_LEN must lie in 2..127");
    end

    localparam logic [7:0] TLV_REPORT_ONLY_ONE = 8'(TLV_LEN);
    localparam logic [7:0] TLV_REPORT_ONLY_TWO = 8'(2 * TLV_LEN);

    typedef enum {
        ST_IDLE, ST_FLAGS_HI, ST_FLAGS_LO, ST_CODE, ST_SEQ_HI, ST_SEQ_LO,
        ST_TLV_REPORT_ONLY, ST_LB_CMD, ST_PAY
    } oam_tx_st_e;

    function automatic logic req_ok(input oam_req_s r, input oam_perm_e p,
                                    input logic pas, input logic evs,
                                    input logic lbs);
        logic ok;
        ok = 1'b0;
        case (p)
            PERM_LISTEN_ONLY:       ok = 1'b0;
            PERM_FAULT_REPORT_ONLY: ok = (r.code == CODE_TLV_REPORT_ONLY);
            PERM_TLV_REPORT_ONLY:   ok = (r.code == CODE_TLV_REPORT_ONLY);
            PERM_ANY: begin
                case (r.code)
                    CODE_TLV_REPORT_ONLY:     ok = 1'b1;
                    CODE_EVENT:    ok = evs && r.len != 8'h00;
                    CODE_VAR_REQ:  ok = !pas && r.len != 8'h00;
                    CODE_VAR_RSP:  ok = r.len != 8'h00;
                    CODE_LOOPBACK: ok = !pas && lbs &&
                        (r.lb_cmd == LB_ENABLE ||
                         r.lb_cmd == LB_DISABLE);
                    CODE_ORG:      ok = r.len >= OUI_BYTES;
                    default:       ok = 1'b0;
                endcase
            end
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : req_ok

    oam_tx_st_e  st_q,    st_d;
    logic [7:0]  cnt_q,   cnt_d;
    logic [7:0]  code_q,  code_d;
    logic [7:0]  len_q,   len_d;
    logic [7:0]  lb_q,    lb_d;
    logic [7:0]  tlv_report_only_q,  tlv_report_only_d;
    logic [15:0] seq_q,   seq_d;
    logic [2:0]  crit_q,  crit_d;
    oam_byte_s   tx_q,    tx_d;
    logic        ack_q,   ack_d;
    logic        rej_q,   rej_d;
    logic        rdy_q,   rdy_d;
    logic [15:0] flags;
    logic [7:0]  tlv_report_only_byte;
    int          k;

    // outgoing flags; reserved bits zero, reserved state code suppressed
    always_comb begin
        flags = 16'h0000;
        flags[FLG_CRIT_LSB +: FLG_CRIT_W] = crit_q;
        flags[FLG_LOC_LSB +: 2] = (i_loc_state == STATE_BAD) ? STATE_SAFE
                                                              : i_loc_state;
        flags[FLG_REM_LSB +: 2] = (i_rem_state == STATE_BAD) ? STATE_SAFE
                                                              : i_rem_state;
    end

    // tlv byte at cnt_q; type bytes forced to the two legal codes
    always_comb begin
        k = 0;
        if (cnt_q < TLV_REPORT_ONLY_ONE) begin
            k = int'(cnt_q);
            tlv_report_only_byte = (k == 0) ? TLV_LOCAL
                                 : i_loc_tlv[8*(TLV_LEN-1-k) +: 8];
        end else begin
            k = int'(cnt_q) - TLV_LEN;
            tlv_report_only_byte = (k == 0) ? TLV_REMOTE
                                 : i_rem_tlv[8*(TLV_LEN-1-k) +: 8];
        end
    end

    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        code_d = code_q;
        len_d  = len_q;
        lb_d   = lb_q;
        tlv_report_only_d = tlv_report_only_q;
        seq_d  = seq_q;
        crit_d = i_ctl_valid ? i_ctl_crit : crit_q;
        tx_d   = '0;
        ack_d  = 1'b0;
        rej_d  = 1'b0;
        case (st_q)
            ST_IDLE: begin
                if (i_req_valid) begin
                    if (req_ok(i_req, i_local_pdu, i_passive,
                               i_link_event_support,
                               i_remote_loopback_support)) begin
                        ack_d  = 1'b1;
                        code_d = i_req.code;
                        len_d  = i_req.len;
                        lb_d   = i_req.lb_cmd;
                        if (i_local_pdu == PERM_FAULT_REPORT_ONLY)
                            tlv_report_only_d = 8'h00;
                        else if (!i_remote_state_valid)
                            tlv_report_only_d = TLV_REPORT_ONLY_ONE;
                        else
                            tlv_report_only_d = TLV_REPORT_ONLY_TWO;
                        st_d = ST_FLAGS_HI;
                    end else begin
                        rej_d = 1'b1;
                    end
                end
            end
            // header starts straight with flags: no tag field exists
            ST_FLAGS_HI: begin
                tx_d = '{valid: 1'b1, data: flags[15:8], last: 1'b0};
                st_d = ST_FLAGS_LO;
            end
            ST_FLAGS_LO: begin
                tx_d = '{valid: 1'b1, data: flags[7:0], last: 1'b0};
                st_d = ST_CODE;
            end
            ST_CODE: begin
                tx_d  = '{valid: 1'b1, data: code_q, last: 1'b0};
                cnt_d = len_q;
                case (code_q)
                    CODE_TLV_REPORT_ONLY: begin
                        cnt_d = 8'h00;
                        if (tlv_report_only_q == 8'h00) begin
                            tx_d.last = 1'b1;
                            st_d      = ST_IDLE;
                        end else begin
                            st_d = ST_TLV_REPORT_ONLY;
                        end
                    end
                    CODE_EVENT:    st_d = ST_SEQ_HI;
                    CODE_LOOPBACK: st_d = ST_LB_CMD;
                    default:       st_d = ST_PAY;
                endcase
            end
            ST_SEQ_HI: begin
                tx_d = '{valid: 1'b1, data: seq_q[15:8], last: 1'b0};
                st_d = ST_SEQ_LO;
            end
            ST_SEQ_LO: begin
                tx_d  = '{valid: 1'b1, data: seq_q[7:0], last: 1'b0};
                seq_d = seq_q + 16'h0001;
                st_d  = ST_PAY;
            end
            ST_TLV_REPORT_ONLY: begin
                tx_d  = '{valid: 1'b1, data: tlv_report_only_byte,
                          last: cnt_q == tlv_report_only_q - 8'h01};
                cnt_d = cnt_q + 8'h01;
                if (tx_d.last) st_d = ST_IDLE;
            end
            ST_LB_CMD: begin
                tx_d = '{valid: 1'b1, data: lb_q, last: 1'b1};
                st_d = ST_IDLE;
            end
            ST_PAY: begin
                if (i_pay_valid && rdy_q) begin
                    tx_d  = '{valid: 1'b1, data: i_pay_data,
                              last: cnt_q == 8'h01};
                    cnt_d = cnt_q - 8'h01;
                    if (tx_d.last) st_d = ST_IDLE;
                end
            end
            default: st_d = ST_IDLE;
        endcase
        rdy_d = (st_d == ST_PAY);
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q   <= ST_IDLE;
            cnt_q  <= 8'h00;
            code_q <= 8'h00;
            len_q  <= 8'h00;
            lb_q   <= 8'h00;
            tlv_report_only_q <= 8'h00;
            seq_q  <= 16'h0000;
            crit_q <= 3'h0;
            tx_q   <= '0;
            ack_q  <= 1'b0;
            rej_q  <= 1'b0;
            rdy_q  <= 1'b0;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            code_q <= code_d;
            len_q  <= len_d;
            lb_q   <= lb_d;
            tlv_report_only_q <= tlv_report_only_d;
            seq_q  <= seq_d;
            crit_q <= crit_d;
            tx_q   <= tx_d;
            ack_q  <= ack_d;
            rej_q  <= rej_d;
            rdy_q  <= rdy_d;
        end
    end

    assign o_tx        = tx_q;
    assign o_req_ack   = ack_q;
    assign o_req_rej   = rej_q;
    assign o_pay_ready = rdy_q;
    assign o_loc_crit  = crit_q;

    oam_rx_parser u_rx (
        .i_clk                (i_clk),
        .i_rst                (i_rst),
        .i_local_pdu          (i_local_pdu),
        .i_link_event_support (i_link_event_support),
        .i_rx                 (i_rx),
        .o_ind_valid          (o_ind_valid),
        .o_ind                (o_ind),
        .o_rem_crit           (o_rem_crit)
    );

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_ctl_loads: assert property (
        i_ctl_valid |=> o_loc_crit == $past(i_ctl_crit))
        else $error("critical flags not loaded from control request");
    a_ctl_flags_out: assert property (
        st_q == ST_FLAGS_LO && !i_ctl_valid
        |=> o_tx.data[FLG_CRIT_LSB +: FLG_CRIT_W] == o_loc_crit)
        else $error("critical flags not taken from control request");
    a_listen_silent: assert property (
        o_req_ack |-> $past(i_local_pdu) != PERM_LISTEN_ONLY)
        else $error("pdu accepted in listen-only");
    a_tlv_tlv_report_only_only: assert property (
        o_req_ack && $past(i_local_pdu) == PERM_TLV_REPORT_ONLY
        |-> code_q == CODE_TLV_REPORT_ONLY)
        else $error("non-information pdu in tlv-report-only");
    a_fault_no_tlv: assert property (
        o_req_ack && $past(i_local_pdu) == PERM_FAULT_REPORT_ONLY
        |-> code_q == CODE_TLV_REPORT_ONLY ##3 o_tx.valid && o_tx.last)
        else $error("fault report pdu not three header bytes");
    a_local_only: assert property (
        o_req_ack && $past(i_local_pdu) != PERM_FAULT_REPORT_ONLY
        && !$past(i_remote_state_valid) |-> tlv_report_only_q == TLV_REPORT_ONLY_ONE)
        else $error("remote tlv sent with peer state unknown");
    a_local_remote: assert property (
        o_req_ack && $past(i_local_pdu) != PERM_FAULT_REPORT_ONLY
        && $past(i_remote_state_valid) |-> tlv_report_only_q == TLV_REPORT_ONLY_TWO)
        else $error("information pdu lacks remote tlv");
    a_seq_bytes: assert property (
        st_q == ST_SEQ_HI |=> o_tx.valid
        && o_tx.data == $past(seq_q[15:8])
        ##1 o_tx.data == $past(seq_q[7:0], 2))
        else $error("sequence number bytes wrong");
    a_event_nonempty: assert property (
        o_req_ack && code_q == CODE_EVENT |-> len_q != 8'h00)
        else $error("event pdu without link event tlv");
    a_var_nonempty: assert property (
        o_req_ack && (code_q == CODE_VAR_REQ || code_q == CODE_VAR_RSP)
        |-> len_q != 8'h00)
        else $error("empty variable pdu accepted");
    a_lb_cmd_legal: assert property (
        o_tx.valid && $past(st_q) == ST_LB_CMD
        |-> (o_tx.data == LB_ENABLE || o_tx.data == LB_DISABLE)
        && o_tx.last)
        else $error("illegal loopback command sent");
    a_tlv_types: assert property (
        o_tx.valid && $past(st_q) == ST_TLV_REPORT_ONLY
        && ($past(cnt_q) == 8'h00 || $past(cnt_q) == TLV_REPORT_ONLY_ONE)
        |-> (o_tx.data == TLV_LOCAL || o_tx.data == TLV_REMOTE))
        else $error("illegal information tlv type sent");

    c_tlv_report_only_two: cover property (o_req_ack && tlv_report_only_q == TLV_REPORT_ONLY_TWO);
    c_event_pdu: cover property (o_req_ack && code_q == CODE_EVENT);
    c_loopback: cover property (o_req_ack && code_q == CODE_LOOPBACK);
    c_reject: cover property (o_req_rej);

endmodule : oam_pdu_formatter

//--- oam_pdu_formatter_bench.sv
// self-checking bench for the oam pdu formatter
`timescale 1ns/1ps
module oam_pdu_formatter_bench;
    import oam_pkg::*;
    localparam int TL = 2;
    logic       i_clk = 1'b0;
    logic       i_rst = 1'b1;
    oam_perm_e  local_pdu = PERM_ANY;
    logic       passive, lev, lbs, rvalid, ctl_valid, req_valid, pay_valid;
    logic [2:0] ctl_crit;
    logic [7:0] pay_data;
    oam_req_s   req;
    oam_byte_s  tx, rx;
    logic       req_ack, req_rej, pay_ready, ind_valid;
    oam_ind_s   ind;
    logic [2:0] rem_crit, loc_crit;
    int         n_errors = 0;
    int         num_checks = 0;
    int         n_ind = 0;
    int         cycles = 0;

    always #5 i_clk = ~i_clk;

    oam_pdu_formatter #(.TLV_LEN(TL)) uut (
        .i_clk(i_clk), .i_rst(i_rst), .i_local_pdu(local_pdu),
        .i_passive(passive), .i_link_event_support(lev),
        .i_remote_loopback_support(lbs), .i_remote_state_valid(rvalid),
        .i_loc_state(2'h1), .i_rem_state(2'h2),
        .i_loc_tlv(16'h7755), .i_rem_tlv(16'h6644),
        .i_ctl_valid(ctl_valid), .i_ctl_crit(ctl_crit),
        .i_req_valid(req_valid), .i_req(req), .o_req_ack(req_ack),
        .o_req_rej(req_rej), .i_pay_valid(pay_valid),
        .i_pay_data(pay_data), .o_pay_ready(pay_ready), .o_tx(tx),
        .i_rx(rx), .o_ind_valid(ind_valid), .o_ind(ind),
        .o_rem_crit(rem_crit), .o_loc_crit(loc_crit));

    oam_peer peer (.i_clk(i_clk), .i_tx(tx), .o_rx(rx));

    // tests need about 300 cycles
    always @(posedge i_clk) begin
        cycles++;
        if (ind_valid === 1'b1) n_ind++;
        if (cycles == 20000) begin
            n_errors++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t seen %0h expected %0h", $time,
                     seen, exp);
        end
    endtask : check

    // flags low byte: remote state 2, local state 1
    function automatic logic [7:0] flo(input logic [2:0] c);
        return {1'b0, 2'h2, 2'h1, c};
    endfunction : flo

    function automatic int frm_diff(input logic [7:0] e[$]);
        int d;
        d = (peer.frame.size() != e.size());
        foreach (e[i])
            if (i < peer.frame.size() && peer.frame[i] !== e[i]) d++;
        return d;
    endfunction : frm_diff

    // request, feed payload A0.., wait for the frame
    task automatic xfer(input logic [7:0] code, input logic [7:0] len,
                        input logic [7:0] cmd, output logic [2:0] res);
        int   n0, k, lim;
        logic rdy;
        n0 = peer.n_frames;
        k = 0;
        @(negedge i_clk);
        req_valid = 1'b1;
        req = '{code: code, len: len, lb_cmd: cmd};
        @(posedge i_clk);
        @(negedge i_clk);
        req_valid = 1'b0;
        res[2:1] = {req_ack, req_rej};
        lim = (req_ack === 1'b1) ? 300 : 10;
        for (int w = 0; w < lim && peer.n_frames == n0; w++) begin
            pay_data = 8'hA0 + k[7:0];
            pay_valid = (k < len);
            rdy = pay_ready;
            @(posedge i_clk);
            if (rdy === 1'b1 && pay_valid) k++;
            @(negedge i_clk);
        end
        pay_valid = 1'b0;
        res[0] = (peer.n_frames != n0);
    endtask : xfer

    task automatic ctl(input logic [2:0] c);
        @(negedge i_clk);
        ctl_valid = 1'b1;
        ctl_crit = c;
        @(negedge i_clk);
        ctl_valid = 1'b0;
    endtask : ctl

    task automatic t_perm();
        logic [2:0] r;
        local_pdu = PERM_LISTEN_ONLY;
        xfer(CODE_TLV_REPORT_ONLY, 8'h00, 8'h00, r);
        check(r, 3'b010);
        local_pdu = PERM_TLV_REPORT_ONLY;
        xfer(CODE_EVENT, 8'h02, 8'h00, r);
        check(r, 3'b010);
        xfer(CODE_TLV_REPORT_ONLY, 8'h00, 8'h00, r);
        check(r, 3'b101);
        check(frm_diff('{8'h00, flo(3'h0), 8'h00, 8'h01, 8'h55}), 0);
        ctl(3'h5);
        check(loc_crit, 3'h5);
        local_pdu = PERM_FAULT_REPORT_ONLY;
        xfer(CODE_TLV_REPORT_ONLY, 8'h00, 8'h00, r);
        check(frm_diff('{8'h00, flo(3'h5), 8'h00}), 0);
        xfer(CODE_LOOPBACK, 8'h00, LB_ENABLE, r);
        check(r, 3'b010);
        ctl(3'h0);
        local_pdu = PERM_ANY;
        rvalid = 1'b1;
        xfer(CODE_TLV_REPORT_ONLY, 8'h00, 8'h00, r);
        check(frm_diff('{8'h00, flo(3'h0), 8'h00, 8'h01, 8'h55,
                         8'h02, 8'h44}), 0);
        $display("test permissions done");
    endtask : t_perm

    task automatic t_event();
        logic [2:0] r;
        xfer(CODE_EVENT, 8'h02, 8'h00, r);
        check(frm_diff('{8'h00, flo(3'h0), 8'h01, 8'h00, 8'h00,
                         8'hA0, 8'hA1}), 0);
        xfer(CODE_EVENT, 8'h01, 8'h00, r);
        check(frm_diff('{8'h00, flo(3'h0), 8'h01, 8'h00, 8'h01,
                         8'hA0}), 0);
        xfer(CODE_EVENT, 8'h00, 8'h00, r);
        check(r, 3'b010);
        xfer(CODE_VAR_REQ, 8'h00, 8'h00, r);
        check(r, 3'b010);
        xfer(CODE_VAR_RSP, 8'h00, 8'h00, r);
        check(r, 3'b010);
        xfer(CODE_VAR_RSP, 8'h01, 8'h00, r);
        check(frm_diff('{8'h00, flo(3'h0), 8'h03, 8'hA0}), 0);
        xfer(CODE_ORG, 8'h03, 8'h00, r);
        check(frm_diff('{8'h00, flo(3'h0), 8'hFE, 8'hA0, 8'hA1,
                         8'hA2}), 0);
        $display("test event and variable done");
    endtask : t_event

    task automatic t_loop();
        logic [2:0] r;
        logic [7:0] cmds[5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'hFF};
        foreach (cmds[i]) begin
            xfer(CODE_LOOPBACK, 8'h00, cmds[i], r);
            if (cmds[i] == 8'h01 || cmds[i] == 8'h02) begin
                check(frm_diff('{8'h00, flo(3'h0), 8'h04,
                                 cmds[i]}), 0);
            end else begin
                check(r, 3'b010);
            end
        end
        passive = 1'b1;
        xfer(CODE_LOOPBACK, 8'h00, LB_ENABLE, r);
        check(r, 3'b010);
        passive = 1'b0;
        lbs = 1'b0;
        xfer(CODE_LOOPBACK, 8'h00, LB_DISABLE, r);
        check(r, 3'b010);
        $display("test loopback done");
    endtask : t_loop

    task automatic t_rx();
        int n0;
        n0 = n_ind;
        peer.send('{8'h00, 8'h03, 8'h00, 8'h01, 8'hAA});
        repeat (4) @(negedge i_clk);
        check(n_ind - n0, 1);
        check(ind, {16'h0003, 8'h00, 8'h02});
        check(rem_crit, 3'h3);
        peer.send('{8'h00, 8'h00, 8'h01, 8'h00, 8'h05, 8'h01});
        repeat (4) @(negedge i_clk);
        check(n_ind - n0, 2);
        check(ind, {16'h0000, 8'h01, 8'h03});
        // link events off: event pdus are held back
        lev = 1'b0;
        peer.send('{8'h00, 8'h00, 8'h01, 8'h00, 8'h06, 8'h01});
        repeat (4) @(negedge i_clk);
        check(n_ind - n0, 2);
        lev = 1'b1;
        $display("test receive done");
    endtask : t_rx

    initial begin
        passive = 1'b0;
        lev = 1'b1;
        lbs = 1'b1;
        rvalid = 1'b0;
        ctl_valid = 1'b0;
        ctl_crit = 3'h0;
        req_valid = 1'b0;
        req = '0;
        pay_valid = 1'b0;
        pay_data = 8'h00;
        repeat (20) @(posedge i_clk);
        @(negedge i_clk);
        i_rst = 1'b0;
        t_perm();
        t_event();
        t_loop();
        t_rx();
        conclude();
    end
endmodule : oam_pdu_formatter_bench

//--- oam_peer.sv
// remote peer model: captures sent pdus, sends pdus to the block
`timescale 1ns/1ps
module oam_peer
    import oam_pkg::*;
(
    // clock
    input  wire logic      i_clk,
    // link bytes
    input  wire oam_byte_s i_tx,
    output oam_byte_s      o_rx
);
    logic [7:0] cur[$];
    logic [7:0] frame[$];
    int         n_frames = 0;

    initial o_rx = '{valid: 1'b0, data: 8'hFF, last: 1'b0};

    always @(posedge i_clk) begin
        if (i_tx.valid === 1'b1) begin
            cur.push_back(i_tx.data);
            if (i_tx.last === 1'b1) begin
                frame    = cur;
                cur      = {};
                n_frames = n_frames + 1;
            end
        end
    end

    // untagged frame, flags first; idle data is the inverse of the last
    task automatic send(input logic [7:0] b[$]);
        for (int k = 0; k < b.size(); k++) begin
            @(negedge i_clk);
            o_rx <= '{valid: 1'b1, data: b[k],
                      last: k == b.size() - 1};
        end
        @(negedge i_clk);
        o_rx <= '{valid: 1'b0, data: ~o_rx.data, last: 1'b0};
    endtask : send
endmodule : oam_peer

//--- oam_pkg.sv
// shared constants and carrier types for the oam pdu formatter
package oam_pkg;

    // pdu code field values
    localparam logic [7:0] CODE_TLV_REPORT_ONLY     = 8'h00;
    localparam logic [7:0] CODE_EVENT    = 8'h01;
    localparam logic [7:0] CODE_VAR_REQ  = 8'h02;
    localparam logic [7:0] CODE_VAR_RSP  = 8'h03;
    localparam logic [7:0] CODE_LOOPBACK = 8'h04;
    localparam logic [7:0] CODE_ORG      = 8'hFE;

    // information tlv types and loopback commands that may be sent; oui byte count
    localparam logic [7:0] TLV_LOCAL   = 8'h01;
    localparam logic [7:0] TLV_REMOTE  = 8'h02;
    localparam logic [7:0] LB_ENABLE   = 8'h01;
    localparam logic [7:0] LB_DISABLE  = 8'h02;
    localparam logic [7:0] OUI_BYTES   = 8'h03;

    // flags field layout
    localparam int         FLG_CRIT_LSB = 0;
    localparam int         FLG_CRIT_W   = 3;
    localparam int         FLG_LOC_LSB  = 3;
    localparam int         FLG_REM_LSB  = 5;
    localparam logic [1:0] STATE_BAD    = 2'h3;
    localparam logic [1:0] STATE_SAFE   = 2'h0;

    // rx header byte positions
    localparam logic [7:0] HDR_FLG_HI = 8'h00;
    localparam logic [7:0] HDR_FLG_LO = 8'h01;
    localparam logic [7:0] HDR_CODE   = 8'h02;
    localparam logic [7:0] IDX_MAX    = 8'hFF;

    typedef enum logic [1:0] {
        PERM_LISTEN_ONLY,
        PERM_FAULT_REPORT_ONLY,
        PERM_TLV_REPORT_ONLY,
        PERM_ANY
    } oam_perm_e;

    typedef struct packed {
        logic [7:0] code;
        logic [7:0] len;
        logic [7:0] lb_cmd;
    } oam_req_s;

    typedef struct packed {
        logic [15:0] flags;
        logic [7:0]  code;
        logic [7:0]  len;
    } oam_ind_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       last;
    } oam_byte_s;

endpackage : oam_pkg

//--- oam_rx_parser.sv
// receive side: header parse and indication toward the local client
`timescale 1ns/1ps
module oam_rx_parser
    import oam_pkg::*;
(
    // clock and reset
    input  wire logic      i_clk,
    input  wire logic      i_rst,
    // configuration
    input  wire oam_perm_e i_local_pdu,
    input  wire logic      i_link_event_support,
    // received pdu bytes
    input  wire oam_byte_s i_rx,
    // indication
    output logic           o_ind_valid,
    output oam_ind_s       o_ind,
    output logic [2:0]     o_rem_crit
);

    logic [7:0]  idx_q,   idx_d;
    logic [15:0] flg_q,   flg_d;
    logic [7:0]  code_q,  code_d;
    logic        ind_v_q, ind_v_d;
    oam_ind_s    ind_q,   ind_d;
    logic [2:0]  crit_q,  crit_d;
    logic        deliver;

    always_comb begin
        idx_d   = idx_q;
        flg_d   = flg_q;
        code_d  = code_q;
        ind_v_d = 1'b0;
        ind_d   = ind_q;
        crit_d  = crit_q;
        deliver = 1'b0;
        if (i_rx.valid) begin
            if (idx_q == HDR_FLG_HI) flg_d[15:8] = i_rx.data;
            if (idx_q == HDR_FLG_LO) flg_d[7:0]  = i_rx.data;
            if (idx_q == HDR_CODE)   code_d      = i_rx.data;
            if (idx_q != IDX_MAX)    idx_d       = idx_q + 8'h01;
            // event pdus pass only when local pdu is PERM_ANY and link events are on
            deliver = (code_d == CODE_TLV_REPORT_ONLY) ||
                      (i_local_pdu == PERM_ANY &&
                       (code_d != CODE_EVENT || i_link_event_support));
            if (i_rx.last) begin
                idx_d = HDR_FLG_HI;
                if (idx_q >= HDR_CODE && deliver) begin
                    ind_v_d    = 1'b1;
                    ind_d.flags = flg_d;
                    ind_d.code = code_d;
                    ind_d.len  = idx_q - HDR_CODE;
                    crit_d = flg_d[FLG_CRIT_LSB +: FLG_CRIT_W];
                end
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            idx_q   <= 8'h00;
            flg_q   <= 16'h0000;
            code_q  <= 8'h00;
            ind_v_q <= 1'b0;
            ind_q   <= '0;
            crit_q  <= 3'h0;
        end else begin
            idx_q   <= idx_d;
            flg_q   <= flg_d;
            code_q  <= code_d;
            ind_v_q <= ind_v_d;
            ind_q   <= ind_d;
            crit_q  <= crit_d;
        end
    end

    assign o_ind_valid = ind_v_q;
    assign o_ind       = ind_q;
    assign o_rem_crit  = crit_q;

    a_event_forwarded: assert property (
        @(posedge i_clk) disable iff (i_rst)
        i_rx.valid && i_rx.last && idx_q > HDR_CODE && code_q == CODE_EVENT
        && i_local_pdu == PERM_ANY && i_link_event_support
        |=> o_ind_valid && o_ind.code == CODE_EVENT)
        else $error("event pdu not forwarded");

    a_flags_passed: assert property (
        @(posedge i_clk) disable iff (i_rst)
        o_ind_valid |-> o_rem_crit == o_ind.flags[FLG_CRIT_W-1:0])
        else $error("peer critical flags not delivered");

endmodule : oam_rx_parser
